// ---- shared/bph_pkg.sv ----
// Purpose: constants and carriers for the port configuration header head
// Assumes: one clock, synchronous active-high reset
// Notes: dword offsets are byte addresses of aligned words
package bph_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_IDENTITY = 8'h00;
  localparam logic [7:0] OFF_CMD_STAT = 8'h04;
  localparam logic [7:0] OFF_CLASS_REV = 8'h08;
  // identity defaults, arbitrary neutral values
  localparam logic [15:0] MAKER_ID_DEF = 16'h1234;
  localparam logic [15:0] PART_ID_DEF = 16'h5678;
  localparam logic [7:0] REVISION_DEF = 8'h01;
  // class code: bridge, pci-to-pci, interface zero
  localparam logic [7:0] BASE_CLASS_DEF = 8'h06;
  localparam logic [7:0] SUB_CLASS_DEF = 8'h04;
  localparam logic [7:0] PROG_IF_DEF = 8'h00;
  // command bit positions
  localparam int CMD_IO_EN = 0;
  localparam int CMD_MEM_EN = 1;
  localparam int CMD_FWD_EN = 2;
  localparam int CMD_PAR_RESP = 6;
  localparam int CMD_SYSERR_EN = 8;
  localparam int CMD_INT_DIS = 10;
  // status bit positions within the full dword
  localparam int ST_INT_PEND = 19;
  localparam int ST_CAP_LIST = 20;
  localparam int ST_MASTER_PAR = 24;
  localparam int ST_TGT_ABORT = 27;
  localparam int ST_SYS_ERR = 30;
  localparam int ST_PAR_DET = 31;
  // writable command bits and write-one-to-clear status bits
  localparam logic [31:0] CMD_RW_MASK = 32'h0000_0547;
  localparam logic [31:0] ST_W1C_MASK = 32'hC900_0000;
  localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

  // configuration request from upstream
  typedef struct packed {
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bph_cfg_req_s;

  // initialization load of read-only defaults and of the command and sticky status bits
  typedef struct packed {
    logic maker_we;
    logic part_we;
    logic rev_we;
    logic class_we;
    logic cmd_we;
    logic [31:0] data;
  } bph_init_s;

  // events reported by the forwarding logic
  typedef struct packed {
    logic poison_wr_fwd_up;
    logic poison_cpl_prim;
    logic poison_rx_prim;
    logic long_reg_access;
    logic absent_port_access;
    logic acs_violation;
    logic err_msg_up;
  } bph_event_s;
endpackage : bph_pkg

// ---- core/bph_status_bit.sv ----
// Purpose: one sticky status bit, hardware set and write-one clear
// Assumes: set and clear are single-cycle qualified pulses
// Notes: a set in the clear cycle wins so no event is lost
module bph_status_bit (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // events
  input wire logic set_i,
  input wire logic clear_i,
  input wire logic load_i,
  input wire logic load_val_i,
  // state
  output logic bit_o
);
  logic bit_q;
  logic bit_d;

  // set beats clear; initialization load sits between
  always_comb begin
    bit_d = bit_q;
    if (load_i) begin
      bit_d = load_val_i;
    end else if (clear_i) begin
      bit_d = 1'b0;
    end
    if (set_i) begin
      bit_d = 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      bit_q <= 1'b0;
    end else begin
      bit_q <= bit_d;
    end
  end

  assign bit_o = bit_q;
endmodule : bph_status_bit

// ---- core/bph_header_head.sv ----
// Purpose: first three dwords of the bridge header for one switch port
// Assumes: config requests synchronous to ref_clk_i, one per cycle at most
// Notes: read data answers one cycle after the read strobe
// Overview of operation
// - read-only maker and part identity fields
// - command bit 0 gates I/O decode
// - command bit 1 gates memory decode
// - bit 2 clear: secondary requests unsupported
// - forwarding enable ignores messages and completions
// - reserved command and status bits read zero
// - bit 24 set on upstream-forwarded write or primary completion poison if bit 6
// - bit 8 enables error reporting and forwarding
// - bit 10 suppresses INTx and interrupt pins
// - bit 19 shows pending or asserted interrupt
// - bit 20 reads one, capability list
// - upstream: long register access sets bit 27
// - upstream: absent port access sets bit 27
// - downstream ACS violation sets bit 27
// - bit 30 set on upstream error message if bit 8
// - bit 31 set on received primary poison only
// - native error status mirrors legacy bits
// - status bits 24,27,30,31 write-one clear
// - class code reads pci-to-pci bridge
// - revision field loadable by initialization only
// - no subtractive decode on upstream side
module bph_header_head #(
  parameter bit IS_UPSTREAM = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // configuration access from upstream
  input wire bph_pkg::bph_cfg_req_s cfg_req_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  // initialization loader
  input wire bph_pkg::bph_init_s init_i,
  // error and poison events from the datapath
  input wire bph_pkg::bph_event_s event_i,
  // interrupt sources
  input wire logic intx_request_i,
  input wire logic intx_pending_i,
  input wire logic vs_pin_enable_i,
  // bridge control system-error enable
  input wire logic bridge_syserr_en_i,
  // request classification for decode gating
  input wire logic prim_io_req_i,
  input wire logic prim_mem_req_i,
  input wire logic sec_req_i,
  input wire logic sec_req_np_i,
  input wire logic sec_msi_i,
  input wire logic sec_msg_or_cpl_i,
  input wire logic down_err_msg_i,
  // decode and forwarding outcomes
  output logic prim_io_claim_o,
  output logic prim_mem_claim_o,
  output logic sec_fwd_up_o,
  output logic sec_ur_cpl_o,
  output logic sec_drop_o,
  output logic err_msg_fwd_o,
  output logic own_err_report_en_o,
  // interrupt outputs
  output logic intx_msg_o,
  output logic legacy_interrupt_out_n_o,
  output logic virtual_switch_interrupt_out_n_o,
  // native mirrors
  output logic poison_status_o,
  output logic cpl_abort_status_o,
  output logic dev_err_detected_o
);
  logic [15:0] maker_id_q;
  logic [15:0] part_id_q;
  logic [7:0] revision_q;
  logic [23:0] class_q;
  logic [31:0] cmd_q;
  logic [31:0] rdata_q;
  logic rvalid_q;
  logic st_master_par;
  logic st_tgt_abort;
  logic st_sys_err;
  logic st_par_det;
  logic wr_cmd;
  logic [31:0] wmask;
  logic [31:0] status_w;
  logic int_pend;
  logic [3:0] st_set;
  logic [3:0] st_clr;
  logic [3:0] st_q;
  logic [3:0] st_ld_val;
  logic pin_q;
  logic vs_pin_q;

  // byte-enable expansion, used for the command config write path only
  function automatic logic [31:0] be_mask(input logic [3:0] be);
    be_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction : be_mask

  assign wmask = be_mask(cfg_req_i.be);
  assign wr_cmd = cfg_req_i.wr && (cfg_req_i.addr == bph_pkg::OFF_CMD_STAT);

  // identity and class load only from initialization, never config writes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      maker_id_q <= bph_pkg::MAKER_ID_DEF;
      part_id_q <= bph_pkg::PART_ID_DEF;
      revision_q <= bph_pkg::REVISION_DEF;
      class_q <= {bph_pkg::BASE_CLASS_DEF, bph_pkg::SUB_CLASS_DEF,
                  bph_pkg::PROG_IF_DEF};
    end else begin
      if (init_i.maker_we) begin
        maker_id_q <= init_i.data[15:0];
      end
      if (init_i.part_we) begin
        part_id_q <= init_i.data[31:16];
      end
      if (init_i.rev_we) begin
        revision_q <= init_i.data[7:0];
      end
      if (init_i.class_we) begin
        class_q <= init_i.data[31:8];
      end
    end
  end

  // command word: only implemented bits take writes
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      cmd_q <= bph_pkg::WORD_ZERO;
    end else if (init_i.cmd_we) begin
      cmd_q <= init_i.data & bph_pkg::CMD_RW_MASK;
    end else if (wr_cmd) begin
      cmd_q <= (cmd_q & ~(wmask & bph_pkg::CMD_RW_MASK)) |
               (cfg_req_i.wdata & wmask & bph_pkg::CMD_RW_MASK);
    end
  end

  // event qualification for the four sticky status bits
  always_comb begin
    st_set[0] = cmd_q[bph_pkg::CMD_PAR_RESP] &&
                (event_i.poison_wr_fwd_up || event_i.poison_cpl_prim);
    st_set[1] = (IS_UPSTREAM && (event_i.long_reg_access ||
                 event_i.absent_port_access)) ||
                (!IS_UPSTREAM && event_i.acs_violation);
    st_set[2] = cmd_q[bph_pkg::CMD_SYSERR_EN] && event_i.err_msg_up;
    st_set[3] = event_i.poison_rx_prim;
  end

  assign st_clr[0] = wr_cmd && cfg_req_i.wdata[bph_pkg::ST_MASTER_PAR] && cfg_req_i.be[3];
  assign st_clr[1] = wr_cmd && cfg_req_i.wdata[bph_pkg::ST_TGT_ABORT] && cfg_req_i.be[3];
  assign st_clr[2] = wr_cmd && cfg_req_i.wdata[bph_pkg::ST_SYS_ERR] && cfg_req_i.be[3];
  assign st_clr[3] = wr_cmd && cfg_req_i.wdata[bph_pkg::ST_PAR_DET] && cfg_req_i.be[3];
  assign st_ld_val = {init_i.data[bph_pkg::ST_PAR_DET], init_i.data[bph_pkg::ST_SYS_ERR],
                      init_i.data[bph_pkg::ST_TGT_ABORT], init_i.data[bph_pkg::ST_MASTER_PAR]};

  // one sticky cell per write-one-clear status bit
  generate
    for (genvar i = 0; i < 4; i++) begin : g_status
      bph_status_bit u_bit (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .set_i(st_set[i]),
        .clear_i(st_clr[i]),
        .load_i(init_i.cmd_we),
        .load_val_i(st_ld_val[i]),
        .bit_o(st_q[i])
      );
    end
  endgenerate

  assign st_master_par = st_q[0];
  assign st_tgt_abort = st_q[1];
  assign st_sys_err = st_q[2];
  assign st_par_det = st_q[3];

  // interrupt pending: internal message or enabled pin asserted
  assign int_pend = intx_pending_i || !pin_q ||
                    (vs_pin_enable_i && !vs_pin_q);

  // assembled status half; everything else reads zero
  always_comb begin
    status_w = bph_pkg::WORD_ZERO;
    status_w[bph_pkg::ST_INT_PEND] = int_pend;
    status_w[bph_pkg::ST_CAP_LIST] = 1'b1;
    status_w[bph_pkg::ST_MASTER_PAR] = st_master_par;
    status_w[bph_pkg::ST_TGT_ABORT] = st_tgt_abort;
    status_w[bph_pkg::ST_SYS_ERR] = st_sys_err;
    status_w[bph_pkg::ST_PAR_DET] = st_par_det;
  end

  // read path, registered; unmapped offsets return zero
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_q <= bph_pkg::WORD_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= cfg_req_i.rd;
      if (cfg_req_i.rd) begin
        case (cfg_req_i.addr)
          bph_pkg::OFF_IDENTITY: rdata_q <= {part_id_q, maker_id_q};
          bph_pkg::OFF_CMD_STAT: rdata_q <= status_w | cmd_q;
          bph_pkg::OFF_CLASS_REV: rdata_q <= {class_q, revision_q};
          default: rdata_q <= bph_pkg::WORD_ZERO;
        endcase
      end
    end
  end

  // decode gating: positive decode only, no subtractive claim
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      prim_io_claim_o <= 1'b0;
      prim_mem_claim_o <= 1'b0;
      sec_fwd_up_o <= 1'b0;
      sec_ur_cpl_o <= 1'b0;
      sec_drop_o <= 1'b0;
    end else begin
      prim_io_claim_o <= prim_io_req_i && cmd_q[bph_pkg::CMD_IO_EN];
      prim_mem_claim_o <= prim_mem_req_i && cmd_q[bph_pkg::CMD_MEM_EN];
      // messages and completions pass whatever the enable says; msi is a posted write
      sec_fwd_up_o <= sec_msg_or_cpl_i ||
                      ((sec_req_i || sec_msi_i) && cmd_q[bph_pkg::CMD_FWD_EN]);
      sec_ur_cpl_o <= !sec_msg_or_cpl_i && sec_req_i && sec_req_np_i && !sec_msi_i &&
                      !cmd_q[bph_pkg::CMD_FWD_EN];
      sec_drop_o <= !sec_msg_or_cpl_i && (sec_msi_i || (sec_req_i && !sec_req_np_i)) &&
                    !cmd_q[bph_pkg::CMD_FWD_EN];
    end
  end

  // error reporting enables and native mirrors
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      err_msg_fwd_o <= 1'b0;
      own_err_report_en_o <= 1'b0;
      poison_status_o <= 1'b0;
      cpl_abort_status_o <= 1'b0;
      dev_err_detected_o <= 1'b0;
    end else begin
      err_msg_fwd_o <= down_err_msg_i && cmd_q[bph_pkg::CMD_SYSERR_EN] &&
                       bridge_syserr_en_i;
      own_err_report_en_o <= cmd_q[bph_pkg::CMD_SYSERR_EN];
      // mirrors follow the legacy bits with one cycle of lag
      poison_status_o <= st_d_or(st_master_par, st_par_det);
      cpl_abort_status_o <= st_tgt_abort;
      dev_err_detected_o <= st_sys_err;
    end
  end

  function automatic logic st_d_or(input logic a, input logic b);
    st_d_or = a | b;
  endfunction : st_d_or

  // interrupt generation, suppressed by interrupt disable
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      intx_msg_o <= 1'b0;
      pin_q <= 1'b1;
      vs_pin_q <= 1'b1;
    end else begin
      intx_msg_o <= intx_request_i && !cmd_q[bph_pkg::CMD_INT_DIS];
      pin_q <= !(intx_request_i && !cmd_q[bph_pkg::CMD_INT_DIS]);
      vs_pin_q <= !(intx_request_i && vs_pin_enable_i &&
                    !cmd_q[bph_pkg::CMD_INT_DIS]);
    end
  end

  assign cfg_rdata_o = rdata_q;
  assign cfg_rvalid_o = rvalid_q;
  assign legacy_interrupt_out_n_o = pin_q;
  assign virtual_switch_interrupt_out_n_o = vs_pin_q;
endmodule : bph_header_head

// ---- tb/bph_header_head_monitor.sv ----
// Purpose: port-level checks for the header head
// Assumes: one clock, sync active-high reset
// Notes: status mirrors trail their bit by one cycle, so two in all
module bph_header_head_monitor #(
  parameter bit IS_UPSTREAM = 1'b1
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_i,
  // watched inputs
  input wire bph_pkg::bph_cfg_req_s cfg_req_i,
  input wire bph_pkg::bph_init_s init_i,
  input wire bph_pkg::bph_event_s event_i,
  input wire logic intx_request_i,
  input wire logic bridge_syserr_en_i,
  input wire logic prim_io_req_i,
  input wire logic prim_mem_req_i,
  input wire logic down_err_msg_i,
  // watched outputs
  input wire logic cfg_rvalid_o,
  input wire logic prim_io_claim_o,
  input wire logic prim_mem_claim_o,
  input wire logic sec_fwd_up_o,
  input wire logic sec_ur_cpl_o,
  input wire logic sec_drop_o,
  input wire logic err_msg_fwd_o,
  input wire logic own_err_report_en_o,
  input wire logic legacy_interrupt_out_n_o,
  input wire logic poison_status_o,
  input wire logic cpl_abort_status_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (reset_i);
  // read taken, then answered next cycle
  sequence s_rd_taken;
    cfg_req_i.rd;
  endsequence
  sequence s_answer;
    ##1 cfg_rvalid_o;
  endsequence
  a_read_answer: assert property (s_rd_taken |-> s_answer)
    else $error("read not answered");
  a_no_stray_answer: assert property (!cfg_req_i.rd |=> !cfg_rvalid_o)
    else $error("answer without read");
  a_io_claim_cause: assert property (prim_io_claim_o |-> $past(prim_io_req_i))
    else $error("io claim without request");
  a_mem_claim_cause: assert property (prim_mem_claim_o |-> $past(prim_mem_req_i))
    else $error("memory claim without request");
  a_fwd_excl: assert property (sec_fwd_up_o |-> !sec_ur_cpl_o && !sec_drop_o)
    else $error("forward and refuse together");
  a_err_fwd_gate: assert property (err_msg_fwd_o |->
    $past(down_err_msg_i && bridge_syserr_en_i) && own_err_report_en_o)
    else $error("error message forwarded while gated");
  a_long_sets_abort: assert property (event_i.long_reg_access && IS_UPSTREAM |->
    ##2 cpl_abort_status_o)
    else $error("long access left abort clear");
  a_rx_poison_sets: assert property (event_i.poison_rx_prim |-> ##2 poison_status_o)
    else $error("primary poison not recorded");
  a_abort_cause: assert property ($rose(cpl_abort_status_o) |->
    $past(event_i.long_reg_access || event_i.absent_port_access ||
    event_i.acs_violation || init_i.cmd_we, 2))
    else $error("abort mirror rose without cause");
  a_pin_cause: assert property (!legacy_interrupt_out_n_o |-> $past(intx_request_i))
    else $error("interrupt pin low without request");
endmodule : bph_header_head_monitor

// ---- tb/bph_host_model.sv ----
// Purpose: upstream requester issuing configuration reads and writes
// Assumes: answer one cycle after the read strobe
// Notes: idle address and data are inverted so stale values never match
module bph_host_model (
  // clock
  input wire logic ref_clk_i,
  // request and answer
  output bph_pkg::bph_cfg_req_s cfg_req_o,
  input wire logic [31:0] rdata_i,
  input wire logic rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  initial cfg_req_o = '0;
  // one-cycle strobe, fields scrambled once the edge has taken them
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i) #1;
    cfg_req_o = '{rd: !w, wr: w, addr: a, be: 4'hF, wdata: d};
    @(posedge ref_clk_i) #1;
    cfg_req_o = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: 4'h0, wdata: ~d};
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask : wr
  // a missing answer yields unknowns so no compare can pass
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0000_0000);
    d = (rvalid_i === 1'b1) ? rdata_i : 32'hxxxx_xxxx;
  endtask : rd
endmodule : bph_host_model

// ---- tb/testbench.sv ----
// Purpose: self-checking bench for the header head
// Assumes: upstream flavour, no initialization load
// Notes: inputs move 1 ns after the rising edge
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  bph_pkg::bph_cfg_req_s cfg_req;
  bph_pkg::bph_event_s ev = '0;
  logic [31:0] rdata;
  logic rvalid;
  logic intx_req = 1'b0;
  logic [6:0] dec = '0;
  logic io_c, mem_c, fwd, ur, drop, efwd, oen, pin_n, vpin_n, imsg, pst, abt, derr;
  logic [31:0] r;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  // reset values, then after all-ones writes at 00h..0Ch
  localparam logic [31:0] RST [3] = '{{bph_pkg::PART_ID_DEF, bph_pkg::MAKER_ID_DEF},
    32'h0010_0000, {24'h06_0400, bph_pkg::REVISION_DEF}};
  localparam logic [31:0] RV [4] = '{RST[0], 32'h0010_0547, RST[2], 32'h0000_0000};
  // event table: command, event pulse, expected sticky bits
  localparam logic [15:0] TC [9] = '{16'h0040, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0100, 16'h0000, 16'h0040, 16'h0000};
  localparam logic [6:0] TE [9] = '{7'h40, 7'h40, 7'h10, 7'h08, 7'h04, 7'h01, 7'h01,
    7'h20, 7'h02};
  localparam logic [31:0] TS [9] = '{32'h0100_0000, 32'h0000_0000, 32'h8000_0000,
    32'h0800_0000, 32'h0800_0000, 32'h4000_0000, 32'h0000_0000, 32'h0100_0000,
    32'h0000_0000};
  always #5 ref_clk_i = ~ref_clk_i;
  bph_header_head u_bph_header_head (
    .ref_clk_i, .reset_i, .cfg_req_i(cfg_req), .cfg_rdata_o(rdata), .cfg_rvalid_o(rvalid),
    .init_i('0), .event_i(ev), .intx_request_i(intx_req), .intx_pending_i(1'b0),
    .vs_pin_enable_i(1'b1), .bridge_syserr_en_i(1'b1), .prim_io_req_i(dec[4]),
    .prim_mem_req_i(dec[3]), .sec_req_i(dec[2]), .sec_req_np_i(dec[1]), .sec_msi_i(dec[6]),
    .sec_msg_or_cpl_i(dec[5]), .down_err_msg_i(dec[0]), .prim_io_claim_o(io_c),
    .prim_mem_claim_o(mem_c), .sec_fwd_up_o(fwd), .sec_ur_cpl_o(ur), .sec_drop_o(drop),
    .err_msg_fwd_o(efwd), .own_err_report_en_o(oen), .intx_msg_o(imsg),
    .legacy_interrupt_out_n_o(pin_n), .virtual_switch_interrupt_out_n_o(vpin_n),
    .poison_status_o(pst), .cpl_abort_status_o(abt), .dev_err_detected_o(derr));
  bph_host_model u_bph_host_model (
    .ref_clk_i, .cfg_req_o(cfg_req), .rdata_i(rdata), .rvalid_i(rvalid));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude
  // hang guard, well above the 140 or so cycles needed
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      error_cnt++;
      conclude();
    end
  end
  initial begin
    repeat (20) @(posedge ref_clk_i);
    #1 reset_i = 1'b0;
    for (int i = 0; i < 3; i++) begin
      u_bph_host_model.rd(8'(i * 4), r);
      chk(r, RST[i]);
    end
    for (int i = 0; i < 4; i++) u_bph_host_model.wr(8'(i * 4), 32'hFFFF_FFFF);
    for (int i = 0; i < 4; i++) begin
      u_bph_host_model.rd(8'(i * 4), r);
      chk(r, RV[i]);
    end
    // decode gates off, then on
    for (int k = 0; k < 2; k++) begin
      u_bph_host_model.wr(bph_pkg::OFF_CMD_STAT, k ? 32'h0000_0107 : 32'h0000_0000);
      @(posedge ref_clk_i) #1 dec = 7'h1F;
      @(posedge ref_clk_i) #1 dec = 7'h40;
      chk({30'h0, io_c, mem_c}, {30'h0, k[0], k[0]});
      chk({28'h0, fwd, ur, drop, efwd}, {28'h0, k[0], !k[0], 1'b0, k[0]});
      chk({31'h0, oen}, {31'h0, k[0]});
      // msi write alone, then a message riding with a request
      @(posedge ref_clk_i) #1 dec = 7'h26;
      chk({29'h0, fwd, ur, drop}, {29'h0, k[0], 1'b0, !k[0]});
      @(posedge ref_clk_i) #1 dec = 7'h00;
      chk({29'h0, fwd, ur, drop}, 32'h0000_0004);
    end
    // each event: clear, pulse, write zeros, read sticky bits
    for (int i = 0; i < 9; i++) begin
      u_bph_host_model.wr(bph_pkg::OFF_CMD_STAT, {16'hFF00, TC[i]});
      @(posedge ref_clk_i) #1 ev = bph_pkg::bph_event_s'(TE[i]);
      @(posedge ref_clk_i) #1 ev = '0;
      u_bph_host_model.wr(bph_pkg::OFF_CMD_STAT, {16'h0000, TC[i]});
      u_bph_host_model.rd(bph_pkg::OFF_CMD_STAT, r);
      chk(r & 32'hC900_0000, TS[i]);
      chk({30'h0, pst, derr}, {30'h0, TS[i][24] | TS[i][31], TS[i][30]});
      chk({31'h0, abt}, {31'h0, TS[i][27]});
    end
    u_bph_host_model.wr(bph_pkg::OFF_CMD_STAT, 32'hFF00_0000);
    intx_req = 1'b1;
    repeat (3) @(posedge ref_clk_i);
    #1 chk({29'h0, pin_n, vpin_n, imsg}, 32'h0000_0001);
    u_bph_host_model.rd(bph_pkg::OFF_CMD_STAT, r);
    chk(r, 32'h0018_0000);
    u_bph_host_model.wr(bph_pkg::OFF_CMD_STAT, 32'h0000_0400);
    repeat (3) @(posedge ref_clk_i);
    #1 chk({29'h0, pin_n, vpin_n, imsg}, 32'h0000_0006);
    u_bph_host_model.rd(bph_pkg::OFF_CMD_STAT, r);
    chk(r, 32'h0010_0400);
    conclude();
  end
endmodule : testbench
bind bph_header_head bph_header_head_monitor #(.IS_UPSTREAM(IS_UPSTREAM)) u_mon (
  .ref_clk_i, .reset_i, .cfg_req_i, .init_i, .event_i, .intx_request_i, .bridge_syserr_en_i,
  .prim_io_req_i, .prim_mem_req_i, .down_err_msg_i, .cfg_rvalid_o, .prim_io_claim_o,
  .prim_mem_claim_o, .sec_fwd_up_o, .sec_ur_cpl_o, .sec_drop_o, .err_msg_fwd_o,
  .own_err_report_en_o, .legacy_interrupt_out_n_o, .poison_status_o, .cpl_abort_status_o);
